/* dbr_pkg.sv */
// Constants and types for the dual-port block memory
//
// Summary of operation
// - An 18-Kbit core with input and output registers on each port.
// - Each port has its own clock enable, independent of the other port.
// - Modes: single-port, true dual-port, pseudo dual-port, or ROM.
// - Shapes 16384x1 to 512x36; true dual-port stops at 1024x18.
// - Optional ninth parity bit stored with every data byte; x9, x18 and x36 only.
// - Byte enables count only at 18-bit and 36-bit widths.
// - In multi-port modes the two ports may have different widths.
// - Bits map consecutively, word zero upward, the same for every width.
// - Contents may be preloaded before user operation starts.
// - Address and input data are registered at the array input.
// - Optional output register; when off, read data bypasses it.
// - Normal mode: a write shows no data from the addressed word.
// - Write-through mode: written data appears on the same port's output.
// - Read-before-write shows old contents; x9, x18 and x36 only.
// - Output latches clear asynchronously or synchronously, by configuration.
// - Each port's own reset clears only that port's output latches.
// - The active-low chip-wide reset clears both ports' output latches.
package dbr_pkg;
  localparam int          MEM_KBITS = 18;
  localparam int          ADDR_W    = 14;
  localparam int          DATA_W    = 36;
  localparam int          BYTE_W    = 9;
  localparam int          NBYTES    = MEM_KBITS * 1024 / BYTE_W;
  localparam int          BIDX_W    = 11;
  localparam int          NLANE     = 4;
  localparam logic [35:0] PAR_MASK  = 36'h7fbfdfeff;

  typedef enum logic [1:0] {
    MODE_SP  = 2'b00,
    MODE_TDP = 2'b01,
    MODE_PDP = 2'b10,
    MODE_ROM = 2'b11
  } dbr_mode_e;

  typedef enum logic [1:0] {
    WR_NORMAL  = 2'b00,
    WR_THROUGH = 2'b01,
    WR_RBW     = 2'b10,
    WR_SPARE   = 2'b11
  } dbr_wmode_e;

  typedef enum logic [2:0] {
    W_X1  = 3'b000,
    W_X2  = 3'b001,
    W_X4  = 3'b010,
    W_X9  = 3'b011,
    W_X18 = 3'b100,
    W_X36 = 3'b101
  } dbr_width_e;

  localparam int          AXI_AW     = 4;
  localparam logic [3:0]  OFS_CTRL   = 4'h0;
  localparam logic [3:0]  OFS_IADDR  = 4'h4;
  localparam logic [3:0]  OFS_IDATA  = 4'h8;
  localparam logic [3:0]  OFS_STAT   = 4'hc;
  localparam int          CTL_MODE   = 0;
  localparam int          CTL_OREG_A = 2;
  localparam int          CTL_OREG_B = 3;
  localparam int          CTL_ASYNC  = 4;
  localparam int          CTL_PAR_EN = 5;
  localparam int          CTL_RUN    = 6;
  localparam int          CTL_WM_A   = 7;
  localparam int          CTL_WM_B   = 9;
  localparam int          CTL_WD_A   = 11;
  localparam int          CTL_WD_B   = 14;
  localparam int          CTL_BITS   = 17;
  localparam int          ST_CHIP    = 0;
  localparam int          ST_CLAMP_A = 1;
  localparam int          ST_CLAMP_B = 2;
  localparam logic [16:0] CTRL_RST   = 17'h00000;
  localparam logic [10:0] IADDR_RST  = 11'h000;
  localparam logic [2:0]  SYNC_RST   = 3'h7;
  localparam logic [1:0]  RESP_OKAY  = 2'h0;
  localparam logic [1:0]  RESP_SLVERR = 2'h2;
endpackage : dbr_pkg

/* dbr_sync.sv */
// Three-stage synchroniser for the chip-wide reset pin
`timescale 1ns/1ns
module dbr_sync (
  input  wire logic clk,
  input  wire logic srst,
  input  wire logic pin_n,
  output logic      level_n
);
  import dbr_pkg::*;

  logic [2:0] ff_reg;
  logic [2:0] ff_next;
  logic       lvl_reg;
  logic       lvl_next;

  always_comb begin
    ff_next  = {ff_reg[1:0], pin_n};
    lvl_next = (ff_reg[1] == ff_reg[2]) ? ff_reg[2] : lvl_reg;
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      ff_reg  <= SYNC_RST;
      lvl_reg <= 1'b1;
    end else begin
      ff_reg  <= ff_next;
      lvl_reg <= lvl_next;
    end
  end

  assign level_n = lvl_reg;
endmodule : dbr_sync

/* dbr_port.sv */
// One memory port: input registers, lane mapping, output latch and register
`timescale 1ns/1ns
module dbr_port (
  input  wire logic                clk,
  input  wire logic                srst,
  input  wire logic                ce,
  input  wire logic                we,
  input  wire logic [3:0]          be,
  input  wire logic [13:0]         addr,
  input  wire logic [35:0]         din,
  input  wire logic                out_rst,
  input  wire logic                rst_async,
  input  wire logic                par_en,
  input  wire logic                outreg_en,
  input  wire logic                wr_allow,
  input  wire logic                rd_allow,
  input  wire dbr_pkg::dbr_width_e width,
  input  wire dbr_pkg::dbr_wmode_e wmode,
  input  wire logic [35:0]         rd_bytes,
  output logic [43:0]              lane_idx,
  output logic [35:0]              wr_mask,
  output logic [35:0]              wr_data,
  output logic                     wr_go,
  output logic [35:0]              dout
);
  import dbr_pkg::*;

  logic [13:0] addr_reg, addr_next;
  logic [35:0] din_reg, din_next;
  logic        we_reg, we_next;
  logic [3:0]  be_reg, be_next;
  logic [35:0] latch_reg, latch_next;
  logic [35:0] dout_reg, dout_next;
  logic [1:0]  sh;
  logic        wide, bemode, lane_en, clr;
  logic [13:0] pos;
  logic [2:0]  off;
  logic [10:0] base;
  logic [35:0] wmask, rdata, pmask;

  always_comb begin
    addr_next = addr_reg;
    din_next  = din_reg;
    we_next   = we_reg;
    be_next   = be_reg;
    if (ce) begin
      addr_next = addr;
      din_next  = din;
      we_next   = we;
      be_next   = be;
    end
  end

  always_comb begin
    wide   = (width >= W_X9);
    bemode = (width == W_X18) || (width == W_X36);
    case (width)
      W_X1:    begin sh = 2'd0; wmask = 36'h000000001; end
      W_X2:    begin sh = 2'd1; wmask = 36'h000000003; end
      W_X4:    begin sh = 2'd2; wmask = 36'h00000000f; end
      W_X9:    begin sh = 2'd0; wmask = 36'h0000001ff; end
      W_X18:   begin sh = 2'd1; wmask = 36'h00003ffff; end
      default: begin sh = 2'd2; wmask = 36'hfffffffff; end
    endcase
    pmask = par_en ? 36'hfffffffff : PAR_MASK;
    pos   = addr_reg << sh;
    off   = pos[2:0];
    base  = wide ? pos[10:0] : pos[13:3];
    if (wide) begin
      rdata = rd_bytes & wmask & pmask;
    end else begin
      rdata = {27'h0, 9'(rd_bytes[8:0] >> off)} & wmask;
    end
    for (int k = 0; k < NLANE; k++) begin
      lane_idx[k*11 +: 11] = base + 11'(k);
      lane_en = wide ? (wmask[9*k] && (!bemode || be_reg[k])) : (k == 0);
      if (!lane_en) begin
        wr_mask[k*9 +: 9] = 9'h000;
      end else if (wide) begin
        wr_mask[k*9 +: 9] = par_en ? 9'h1ff : 9'h0ff;
      end else begin
        wr_mask[k*9 +: 9] = 9'(wmask[8:0] << off);
      end
      wr_data[k*9 +: 9] = wide ? din_reg[k*9 +: 9] : 9'(din_reg[8:0] << off);
    end
  end

  assign wr_go = ce && we_reg && wr_allow;
  assign clr   = out_rst && (rst_async || ce);

  always_comb begin
    latch_next = latch_reg;
    dout_next  = dout_reg;
    if (ce) begin
      if (we_reg && wr_allow) begin
        case (wmode)
          WR_THROUGH: latch_next = din_reg & wmask & pmask;
          WR_RBW:     latch_next = wide ? rdata : latch_reg;
          default:    latch_next = latch_reg;
        endcase
      end else if (rd_allow) begin
        latch_next = rdata;
      end
      dout_next = outreg_en ? latch_reg : latch_next;
    end
    if (clr) begin
      latch_next = 36'h000000000;
      dout_next  = 36'h000000000;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      addr_reg  <= 14'h0000;
      din_reg   <= 36'h000000000;
      we_reg    <= 1'b0;
      be_reg    <= 4'h0;
      latch_reg <= 36'h000000000;
      dout_reg  <= 36'h000000000;
    end else begin
      addr_reg  <= addr_next;
      din_reg   <= din_next;
      we_reg    <= we_next;
      be_reg    <= be_next;
      latch_reg <= latch_next;
      dout_reg  <= dout_next;
    end
  end

  assign dout = dout_reg;

  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);

  sequence s_two_ce;
    ce && !out_rst && outreg_en ##1 ce && !out_rst && outreg_en;
  endsequence

  AST_HOLD_NO_CE: assert property (!ce && !out_rst |=> $stable(dout))
    else $error("port output changed without clock enable");
  AST_OREG_TWO: assert property (s_two_ce |=> dout == $past(latch_next, 2))
    else $error("registered read data not two enables late");
  AST_WT_DATA: assert property (ce && !out_rst && we_reg && wr_allow && wmode == WR_THROUGH
                                |=> latch_reg == $past(din_reg & wmask & pmask))
    else $error("write-through data missing from latch");
  AST_NORMAL_WR: assert property (ce && !out_rst && we_reg && wr_allow && wmode == WR_NORMAL
                                  |=> $stable(latch_reg))
    else $error("normal write changed the output latch");
  AST_ASYNC_CLR: assert property (out_rst && rst_async
                                  |=> dout == 36'h0 && latch_reg == 36'h0)
    else $error("async clear did not clear outputs");
  AST_SYNC_WAIT: assert property (out_rst && !rst_async && !ce |=> $stable(dout))
    else $error("sync clear acted without clock enable");
endmodule : dbr_port

/* dbr_block_ram.sv */
// Dual-port block memory with AXI4-Lite configuration and preload
//
// Decided for this implementation: the register addresses and register access over AXI4-Lite.
`timescale 1ns/1ns
module dbr_block_ram (
  input  wire logic        clk,
  input  wire logic        srst,
  input  wire logic        chip_wide_reset_n,
  input  wire logic        a_ce,
  input  wire logic        a_we,
  input  wire logic [3:0]  a_be,
  input  wire logic [13:0] a_addr,
  input  wire logic [35:0] a_din,
  input  wire logic        port_a_output_reset,
  output logic      [35:0] a_dout,
  input  wire logic        b_ce,
  input  wire logic        b_we,
  input  wire logic [3:0]  b_be,
  input  wire logic [13:0] b_addr,
  input  wire logic [35:0] b_din,
  input  wire logic        port_b_output_reset,
  output logic      [35:0] b_dout,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [3:0]  s_axi_awaddr,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  output logic      [1:0]  s_axi_bresp,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  input  wire logic [3:0]  s_axi_araddr,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  output logic      [31:0] s_axi_rdata,
  output logic      [1:0]  s_axi_rresp
);
  import dbr_pkg::*;

  logic [8:0]  mem [NBYTES];
  logic        chip_n, chip_rst, run, rst_async, par_en;
  dbr_mode_e   mode;
  dbr_width_e  wa_raw, wb_raw, wa, wb;
  logic        clamp_a, clamp_b;
  logic        a_wr_allow, a_rd_allow, b_wr_allow, b_rd_allow;
  logic        a_wr_go, b_wr_go;
  logic [43:0] a_idx, b_idx;
  logic [35:0] a_mask, a_data, b_mask, b_data, a_rd, b_rd;

  logic [16:0] ctrl_reg, ctrl_next;
  logic [10:0] iaddr_reg, iaddr_next;
  logic        aw_held_reg, aw_held_next, w_held_reg, w_held_next;
  logic [3:0]  awaddr_reg, awaddr_next, wstrb_reg, wstrb_next;
  logic [31:0] wdata_reg, wdata_next, rdata_reg, rdata_next;
  logic        awready_reg, awready_next, wready_reg, wready_next;
  logic        bvalid_reg, bvalid_next, arready_reg, arready_next;
  logic        rvalid_reg, rvalid_next;
  logic [1:0]  bresp_reg, bresp_next, rresp_reg, rresp_next;
  logic        init_we;
  logic [8:0]  init_data;

  dbr_sync u_sync (
    .clk     (clk),
    .srst    (srst),
    .pin_n   (chip_wide_reset_n),
    .level_n (chip_n)
  );

  assign chip_rst  = !chip_n;
  assign run       = ctrl_reg[CTL_RUN];
  assign rst_async = ctrl_reg[CTL_ASYNC];
  assign par_en    = ctrl_reg[CTL_PAR_EN];
  assign mode      = dbr_mode_e'(ctrl_reg[CTL_MODE +: 2]);
  assign wa_raw    = dbr_width_e'(ctrl_reg[CTL_WD_A +: 3]);
  assign wb_raw    = dbr_width_e'(ctrl_reg[CTL_WD_B +: 3]);

  always_comb begin
    clamp_a = (mode == MODE_TDP) && (wa_raw >= W_X36);
    clamp_b = (mode == MODE_TDP) && (wb_raw >= W_X36);
    wa = clamp_a ? W_X18 : ((wa_raw > W_X36) ? W_X36 : wa_raw);
    wb = clamp_b ? W_X18 : ((wb_raw > W_X36) ? W_X36 : wb_raw);
    a_wr_allow = (mode != MODE_ROM);
    a_rd_allow = (mode != MODE_PDP);
    b_wr_allow = (mode == MODE_TDP);
    b_rd_allow = (mode != MODE_SP);
    for (int k = 0; k < NLANE; k++) begin
      a_rd[k*9 +: 9] = mem[a_idx[k*11 +: 11]];
      b_rd[k*9 +: 9] = mem[b_idx[k*11 +: 11]];
    end
  end

  dbr_port u_port_a (
    .clk       (clk),
    .srst      (srst),
    .ce        (a_ce && run),
    .we        (a_we),
    .be        (a_be),
    .addr      (a_addr),
    .din       (a_din),
    .out_rst   (port_a_output_reset || chip_rst),
    .rst_async (rst_async),
    .par_en    (par_en),
    .outreg_en (ctrl_reg[CTL_OREG_A]),
    .wr_allow  (a_wr_allow),
    .rd_allow  (a_rd_allow),
    .width     (wa),
    .wmode     (dbr_wmode_e'(ctrl_reg[CTL_WM_A +: 2])),
    .rd_bytes  (a_rd),
    .lane_idx  (a_idx),
    .wr_mask   (a_mask),
    .wr_data   (a_data),
    .wr_go     (a_wr_go),
    .dout      (a_dout)
  );

  dbr_port u_port_b (
    .clk       (clk),
    .srst      (srst),
    .ce        (b_ce && run),
    .we        (b_we),
    .be        (b_be),
    .addr      (b_addr),
    .din       (b_din),
    .out_rst   (port_b_output_reset || chip_rst),
    .rst_async (rst_async),
    .par_en    (par_en),
    .outreg_en (ctrl_reg[CTL_OREG_B]),
    .wr_allow  (b_wr_allow),
    .rd_allow  (b_rd_allow),
    .width     (wb),
    .wmode     (dbr_wmode_e'(ctrl_reg[CTL_WM_B +: 2])),
    .rd_bytes  (b_rd),
    .lane_idx  (b_idx),
    .wr_mask   (b_mask),
    .wr_data   (b_data),
    .wr_go     (b_wr_go),
    .dout      (b_dout)
  );

  // Array of 2048 nine-bit bytes; a same-byte collision goes to the higher lane number, to port B on equal lanes
  always_ff @(posedge clk) begin
    if (init_we) begin
      mem[iaddr_reg] <= init_data;
    end
    for (int k = 0; k < NLANE; k++) begin
      if (a_wr_go && |a_mask[k*9 +: 9]) begin
        mem[a_idx[k*11 +: 11]] <= (mem[a_idx[k*11 +: 11]] & ~a_mask[k*9 +: 9])
                                  | (a_data[k*9 +: 9] & a_mask[k*9 +: 9]);
      end
      if (b_wr_go && |b_mask[k*9 +: 9]) begin
        mem[b_idx[k*11 +: 11]] <= (mem[b_idx[k*11 +: 11]] & ~b_mask[k*9 +: 9])
                                  | (b_data[k*9 +: 9] & b_mask[k*9 +: 9]);
      end
    end
  end

  // AXI4-Lite slave
  always_comb begin
    ctrl_next    = ctrl_reg;
    iaddr_next   = iaddr_reg;
    aw_held_next = aw_held_reg;
    w_held_next  = w_held_reg;
    awaddr_next  = awaddr_reg;
    wdata_next   = wdata_reg;
    wstrb_next   = wstrb_reg;
    bvalid_next  = bvalid_reg;
    bresp_next   = bresp_reg;
    rvalid_next  = rvalid_reg;
    rdata_next   = rdata_reg;
    rresp_next   = rresp_reg;
    init_we      = 1'b0;
    init_data    = 9'h000;
    if (s_axi_awvalid && awready_reg) begin
      aw_held_next = 1'b1;
      awaddr_next  = s_axi_awaddr;
    end
    if (s_axi_wvalid && wready_reg) begin
      w_held_next = 1'b1;
      wdata_next  = s_axi_wdata;
      wstrb_next  = s_axi_wstrb;
    end
    if (bvalid_reg && s_axi_bready) begin
      bvalid_next = 1'b0;
    end
    if (aw_held_next && w_held_next && !bvalid_reg) begin
      aw_held_next = 1'b0;
      w_held_next  = 1'b0;
      bvalid_next  = 1'b1;
      bresp_next   = RESP_OKAY;
      if (awaddr_next == OFS_CTRL) begin
        for (int i = 0; i < CTL_BITS; i++) begin
          if (wstrb_next[i/8]) begin
            ctrl_next[i] = wdata_next[i];
          end
        end
      end else if (awaddr_next == OFS_IADDR) begin
        if (|wstrb_next) begin
          iaddr_next = wdata_next[10:0];
        end
      end else if (awaddr_next == OFS_IDATA && !run) begin
        init_we    = wstrb_next[0] || wstrb_next[1];
        init_data  = wdata_next[8:0];
        iaddr_next = iaddr_reg + 11'h001;
      end else begin
        bresp_next = RESP_SLVERR;
      end
    end
    awready_next = !aw_held_next && !bvalid_next;
    wready_next  = !w_held_next && !bvalid_next;
    if (rvalid_reg && s_axi_rready) begin
      rvalid_next = 1'b0;
    end
    if (s_axi_arvalid && arready_reg) begin
      rvalid_next = 1'b1;
      rresp_next  = RESP_OKAY;
      rdata_next  = 32'h00000000;
      if (s_axi_araddr == OFS_CTRL) begin
        rdata_next[CTL_BITS-1:0] = ctrl_reg;
      end else if (s_axi_araddr == OFS_IADDR) begin
        rdata_next[10:0] = iaddr_reg;
      end else if (s_axi_araddr == OFS_IDATA) begin
        rdata_next[8:0] = mem[iaddr_reg];
      end else if (s_axi_araddr == OFS_STAT) begin
        rdata_next[ST_CHIP]    = chip_rst;
        rdata_next[ST_CLAMP_A] = clamp_a;
        rdata_next[ST_CLAMP_B] = clamp_b;
      end else begin
        rresp_next = RESP_SLVERR;
      end
    end
    arready_next = !rvalid_next;
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      ctrl_reg    <= CTRL_RST;
      iaddr_reg   <= IADDR_RST;
      aw_held_reg <= 1'b0;
      w_held_reg  <= 1'b0;
      awaddr_reg  <= 4'h0;
      wdata_reg   <= 32'h00000000;
      wstrb_reg   <= 4'h0;
      awready_reg <= 1'b0;
      wready_reg  <= 1'b0;
      bvalid_reg  <= 1'b0;
      bresp_reg   <= RESP_OKAY;
      arready_reg <= 1'b0;
      rvalid_reg  <= 1'b0;
      rdata_reg   <= 32'h00000000;
      rresp_reg   <= RESP_OKAY;
    end else begin
      ctrl_reg    <= ctrl_next;
      iaddr_reg   <= iaddr_next;
      aw_held_reg <= aw_held_next;
      w_held_reg  <= w_held_next;
      awaddr_reg  <= awaddr_next;
      wdata_reg   <= wdata_next;
      wstrb_reg   <= wstrb_next;
      awready_reg <= awready_next;
      wready_reg  <= wready_next;
      bvalid_reg  <= bvalid_next;
      bresp_reg   <= bresp_next;
      arready_reg <= arready_next;
      rvalid_reg  <= rvalid_next;
      rdata_reg   <= rdata_next;
      rresp_reg   <= rresp_next;
    end
  end

  assign s_axi_awready = awready_reg;
  assign s_axi_wready  = wready_reg;
  assign s_axi_bvalid  = bvalid_reg;
  assign s_axi_bresp   = bresp_reg;
  assign s_axi_arready = arready_reg;
  assign s_axi_rvalid  = rvalid_reg;
  assign s_axi_rdata   = rdata_reg;
  assign s_axi_rresp   = rresp_reg;

  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);

  AST_PDP_DIR: assert property (mode == MODE_PDP |-> !b_wr_go)
    else $error("pseudo dual-port wrote through port B");
  AST_ROM_NOWR: assert property (mode == MODE_ROM |-> !a_wr_go && !b_wr_go)
    else $error("write reached the array in ROM mode");
  AST_TDP_WIDTH: assert property (mode == MODE_TDP |-> wa != W_X36 && wb != W_X36)
    else $error("36-bit width used in true dual-port mode");
  AST_CHIP_CLR: assert property (chip_rst && rst_async
                                 |=> a_dout == 36'h0 && b_dout == 36'h0)
    else $error("chip reset left port data");
  AST_A_ONLY: assert property (port_a_output_reset && !chip_rst && !port_b_output_reset
                               && !(b_ce && run) |=> $stable(b_dout))
    else $error("port A reset disturbed port B");
  AST_INIT_GATE: assert property (init_we |-> !run ##1
                                  mem[$past(iaddr_reg)] == $past(init_data))
    else $error("preload write lost or made while running");
endmodule : dbr_block_ram

/* dbr_fabric_model.sv */
// Fabric-side reader model driving memory port B
`timescale 1ns/1ns
module dbr_fabric_model (
  input  wire logic        clk,
  input  wire logic        srst,
  input  wire logic        req,
  input  wire logic [13:0] addr,
  output logic             ce,
  output logic             we,
  output logic [3:0]       be,
  output logic [13:0]      q_addr,
  output logic [35:0]      din
);
  assign we = 1'b0;
  assign be = 4'hf;
  always_ff @(posedge clk) begin
    if (srst) begin
      ce     <= 1'b0;
      q_addr <= 14'h0;
      din    <= 36'h0;
    end else begin
      ce     <= req;
      q_addr <= req ? addr : ~q_addr;
      din    <= ~din;
    end
  end
endmodule : dbr_fabric_model

/* dbr_block_ram_tb.sv */
// Self-checking bench for the dual-port block memory
`timescale 1ns/1ns
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin err_total++; \
  $display("[FAIL] %0t value mismatch", $time); end end
module dbr_block_ram_tb;
  import dbr_pkg::*;
  localparam logic [31:0] CT = 32'h00011861;
  logic clk = 0, srst = 1, crst_n = 1, a_ce = 0, a_we = 0, a_rst = 0, a_issue = 0, b_req = 0;
  logic        b_ce, b_we;
  logic [3:0]  b_be;
  logic [13:0] a_addr = 0, b_addr;
  logic [35:0] a_din = 0, b_din, a_dout, b_dout;
  logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic awready, wready, bvalid, arready, rvalid;
  logic [3:0]  awaddr = 0, araddr = 0;
  logic [31:0] wdata = 0, rdata;
  logic [1:0]  bresp, rresp;
  logic [35:0] aq[$];
  logic [33:0] rq[$];
  logic [1:0]  bq[$];
  logic [2:0]  sh = 0;
  logic [3:0]  a_be = 4'he;
  logic        oreg = 0;
  logic [8:0]  mem[4];
  logic [8:0]  d;
  int err_total = 0, n_compared = 0, cyc = 0, seed = 25979;
  dbr_fabric_model u_far (.clk(clk), .srst(srst), .req(b_req), .addr(14'h1), .ce(b_ce),
    .we(b_we), .be(b_be), .q_addr(b_addr), .din(b_din));
  dbr_block_ram u_dut (.clk(clk), .srst(srst), .chip_wide_reset_n(crst_n), .a_ce(a_ce),
    .a_we(a_we), .a_be(a_be), .a_addr(a_addr), .a_din(a_din), .port_a_output_reset(a_rst),
    .a_dout(a_dout), .b_ce(b_ce), .b_we(b_we), .b_be(b_be), .b_addr(b_addr), .b_din(b_din),
    .port_b_output_reset(1'b0), .b_dout(b_dout), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_awaddr(awaddr), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_bresp(bresp), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_araddr(araddr), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .s_axi_rdata(rdata), .s_axi_rresp(rresp));
  always #25 clk = ~clk;
  task automatic final_report;
    $display("compared %0d mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : final_report
  always @(posedge clk) begin
    sh <= {sh[1:0], a_issue};
    if (oreg ? sh[2] : sh[1]) `CHK(a_dout, aq.pop_front())
    if (rvalid && rready) `CHK({rresp, rdata}, rq.pop_front())
    if (bvalid && bready) `CHK(bresp, bq.pop_front())
    cyc++;
    if (cyc > 5000) begin
      err_total++;
      final_report();
    end
  end
  task automatic axi_wr(input logic [3:0] a, input logic [31:0] v, input logic [1:0] r);
    bq.push_back(r);
    @(posedge clk);
    awvalid <= 1;
    wvalid <= 1;
    awaddr <= a;
    wdata <= v;
    bready <= 1;
    do begin
      @(posedge clk);
      if (awready) awvalid <= 0;
      if (wready) wvalid <= 0;
    end while ((awvalid && !awready) || (wvalid && !wready));
    do @(posedge clk); while (!bvalid);
    bready <= 0;
  endtask : axi_wr
  task automatic axi_rd(input logic [3:0] a, input logic [31:0] v, input logic [1:0] r);
    rq.push_back({r, v});
    @(posedge clk);
    arvalid <= 1;
    araddr <= a;
    rready <= 1;
    do @(posedge clk); while (!arready);
    arvalid <= 0;
    do @(posedge clk); while (!rvalid);
    rready <= 0;
  endtask : axi_rd
  task automatic pa(input logic w, input logic [13:0] ad, input logic [8:0] v, input logic [8:0] e);
    @(posedge clk);
    a_issue <= 1;
    a_we <= w;
    a_addr <= ad;
    a_din <= {27'h0, v};
    aq.push_back({27'h0, e});
  endtask : pa
  initial begin
    repeat (5) @(posedge clk);
    srst <= 0;
    axi_wr(OFS_IADDR, 32'h0, RESP_OKAY);
    for (int i = 0; i < 4; i++) begin
      mem[i] = 9'($random(seed));
      axi_wr(OFS_IDATA, {23'h0, mem[i]}, RESP_OKAY);
    end
    axi_rd(OFS_STAT, 32'h0, RESP_OKAY);
    axi_wr(OFS_STAT, 32'h0, RESP_SLVERR);
    a_ce <= 1;
    for (int wm = 0; wm < 3; wm++) begin
      axi_wr(OFS_CTRL, CT | (wm << CTL_WM_A), RESP_OKAY);
      if (wm == 0) begin
        axi_rd(OFS_CTRL, CT, RESP_OKAY);
        axi_wr(OFS_IDATA, 32'h0, RESP_SLVERR);
        for (int i = 0; i < 4; i++) pa(0, 14'(i), 9'h0, mem[i]);
      end
      d = 9'($random(seed));
      pa(0, 14'h0, 9'h0, mem[0]);
      pa(1, 14'h2, d, wm == 0 ? mem[0] : wm == 1 ? d : mem[2]);
      mem[2] = d;
      pa(0, 14'h2, 9'h0, d);
      @(posedge clk);
      a_issue <= 0;
      a_we <= 0;
      repeat (4) @(posedge clk);
    end
    b_req <= 1;
    repeat (5) @(posedge clk);
    `CHK(b_dout, {18'h0, mem[3], mem[2]})
    b_req <= 0;
    a_ce <= 0;
    repeat (3) @(posedge clk);
    `CHK(b_dout, {18'h0, mem[3], mem[2]})
    axi_wr(OFS_CTRL, CT | 32'h10, RESP_OKAY);
    a_rst <= 1;
    @(posedge clk);
    a_rst <= 0;
    @(posedge clk);
    `CHK(a_dout, 36'h0)
    `CHK(b_dout, {18'h0, mem[3], mem[2]})
    crst_n <= 0;
    repeat (6) @(posedge clk);
    `CHK(b_dout, 36'h0)
    axi_rd(OFS_STAT, 32'h1, RESP_OKAY);
    crst_n <= 1;
    repeat (6) @(posedge clk);
    axi_wr(OFS_CTRL, CT | 32'h6, RESP_OKAY);
    oreg <= 1'b1;
    a_ce <= 1;
    pa(1, 14'h3, ~mem[3], mem[3]);
    pa(0, 14'h3, 9'h0, mem[3]);
    pa(0, 14'h0, 9'h0, mem[0]);
    @(posedge clk);
    a_issue <= 0;
    a_we <= 0;
    repeat (4) @(posedge clk);
    a_ce <= 0;
    a_rst <= 1;
    repeat (2) @(posedge clk);
    `CHK(a_dout, {27'h0, mem[0]})
    a_ce <= 1;
    @(posedge clk);
    a_ce <= 0;
    a_rst <= 0;
    @(posedge clk);
    `CHK(a_dout, 36'h0)
    final_report();
  end
endmodule : dbr_block_ram_tb
